// file: hdl/icc_card_ctrl.sv
// Card state machine and standard card control registers of an ISA card.
// Assumes decoded ISA strobes synchronous to clk and external serial storage.
//
// What this block does
// - Bus reset: key wait, handle zero, device defaults
// - Return-to-key command always reaches key wait
// - Index 0x00 write sets read port bits 9:2
// - Index 0x01 read compares one identifier bit
// - Command bit 0 resets logical device, keeps handle
// - Command bit 1 returns to key wait
// - Command bit 2 clears the card handle
// - Command register write-only, bits self-clear
// - Matching wake: zero to isolation, else config
// - Any wake write restarts the storage pointer
// - Index 0x04 read returns next resource byte
// - Status bit 0 shows resource byte ready
// - Index 0x06 read/write holds the card handle
// - Index 0x07 reads constant zero
// - Key only as uninterrupted address port writes
// - Drive 0x55/0xAA on one bit, else sense
// - Sensing card that sees both pairs drops out
`timescale 1ns/10ps
`include "icc_map.svh"
module icc_card_ctrl #(
  parameter int ADDR_W = 9,
  parameter int KEY_LEN = `ICC_KEY_LEN
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [11:0] ioAddr,
  input wire logic ioWrStb,
  input wire logic ioRdStb,
  input wire logic ioRdEnd,
  input wire logic [7:0] ioDataIn,
  output logic [7:0] ioDataOut,
  output logic ioDataOe,
  output logic memReq,
  output logic [ADDR_W-1:0] memAddr,
  input wire logic [7:0] memData,
  input wire logic memAck,
  output icc_pkg::icc_state_t cardState,
  output logic [7:0] cardHandle,
  output logic [9:0] readPortAddr,
  output logic ldReset
);

  // Reset release through two flops
  logic rstMeta_q;
  logic rstSync_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  wire logic rst_n = rstSync_q;

  // Port decode
  function automatic logic portHit(input logic [11:0] addr, input logic [11:0] port);
    portHit = (addr == port);
  endfunction

  logic [7:0] index_q;
  logic [7:0] rdPort_q;
  logic [11:0] rdPortFull;
  logic keyOk;
  logic addrWr;
  logic addrRd;
  logic dataWr;
  logic rdPortRd;
  logic regWr;
  logic inIso;
  logic inCfg;

  assign rdPortFull = {`ICC_RDPORT_HI, rdPort_q, `ICC_RDPORT_LO};
  assign addrWr = ioWrStb && portHit(ioAddr, `ICC_ADDR_PORT);
  assign addrRd = ioRdStb && portHit(ioAddr, `ICC_ADDR_PORT);
  assign dataWr = ioWrStb && portHit(ioAddr, `ICC_WDATA_PORT);
  assign rdPortRd = ioRdStb && portHit(ioAddr, rdPortFull) && cardState != icc_pkg::ICC_WAIT_KEY;
  assign regWr = dataWr && cardState != icc_pkg::ICC_WAIT_KEY;
  assign inIso = cardState == icc_pkg::ICC_ISOLATE;
  assign inCfg = cardState == icc_pkg::ICC_CONFIG;

  // Register write strobes
  logic cmdWr;
  logic wakeWr;
  logic wakeMatch;
  logic handleWr;
  logic portWr;

  assign cmdWr = regWr && index_q == `ICC_IDX_CMD;
  assign wakeWr = regWr && index_q == `ICC_IDX_WAKE;
  assign wakeMatch = wakeWr && ioDataIn == cardHandle;
  // Handle and read port only move once the card is picked out
  assign handleWr = regWr && index_q == `ICC_IDX_HANDLE && (inIso || inCfg);
  assign portWr = regWr && index_q == `ICC_IDX_RDPORT && (inIso || inCfg);

  icc_key_detect #(
    .KEY_LEN(KEY_LEN)
  ) u_key (
    .clk(clk),
    .rst_n(rst_n),
    .enable(cardState == icc_pkg::ICC_WAIT_KEY),
    .portWr(addrWr),
    .portRd(addrRd),
    .wrData(ioDataIn),
    .keyOk(keyOk)
  );

  icc_fetch_if fif ();

  icc_res_fetch #(
    .ADDR_W(ADDR_W)
  ) u_fetch (
    .clk(clk),
    .rst_n(rst_n),
    .fif(fif),
    .memReq(memReq),
    .memAddr(memAddr),
    .memData(memData),
    .memAck(memAck)
  );

  // Index register, only outside key wait so key writes do not disturb it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_q <= `ICC_IDX_RST;
    end else if (addrWr && cardState != icc_pkg::ICC_WAIT_KEY) begin
      index_q <= ioDataIn;
    end
  end

  // Read port location
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPort_q <= `ICC_RDPORT_RST;
    end else if (portWr) begin
      rdPort_q <= ioDataIn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readPortAddr <= {`ICC_RDPORT_RST, `ICC_RDPORT_LO};
    end else begin
      readPortAddr <= rdPortFull[9:0];
    end
  end

  // Card handle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cardHandle <= `ICC_HANDLE_RST;
    end else if (cmdWr && ioDataIn[`ICC_CMD_CLRHANDLE]) begin
      cardHandle <= `ICC_HANDLE_RST;
    end else if (handleWr) begin
      cardHandle <= ioDataIn;
    end
  end

  // Logical device reset; high through reset and one cycle after it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ldReset <= 1'b1;
    end else begin
      // Command bits act as pulses and are never stored
      ldReset <= cmdWr && ioDataIn[`ICC_CMD_DEVRST];
    end
  end

  // Isolation engine
  logic [2:0] bitIdx_q;
  logic [6:0] bitCnt_q;
  logic second_q;
  logic drive_q;
  logic sawFirst_q;
  logic isoPend_q;
  logic lose;
  logic isoTake;
  logic resTake;
  logic curBit;
  logic isoRd;

  // A byte not yet fetched reads as zero bits; host pacing avoids this
  assign curBit = fif.ready && fif.data[bitIdx_q];
  assign isoRd = rdPortRd && inIso && index_q == `ICC_IDX_ISOL && bitCnt_q < `ICC_ID_BITS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isoPend_q <= 1'b0;
    end else if (isoRd) begin
      isoPend_q <= 1'b1;
    end else if (ioRdEnd) begin
      isoPend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitIdx_q <= 3'h0;
      bitCnt_q <= 7'h00;
      second_q <= 1'b0;
      drive_q <= 1'b0;
      sawFirst_q <= 1'b0;
    end else if (!inIso) begin
      bitIdx_q <= 3'h0;
      bitCnt_q <= 7'h00;
      second_q <= 1'b0;
      drive_q <= 1'b0;
      sawFirst_q <= 1'b0;
    end else if (isoRd && !second_q) begin
      drive_q <= curBit;
    end else if (isoPend_q && ioRdEnd) begin
      if (!second_q) begin
        second_q <= 1'b1;
        sawFirst_q <= ioDataIn[1:0] == `ICC_SENSE_FIRST;
      end else begin
        second_q <= 1'b0;
        if (!lose) begin
          bitIdx_q <= bitIdx_q + 3'h1;
          bitCnt_q <= bitCnt_q + 7'h01;
        end
      end
    end
  end

  assign lose = inIso && isoPend_q && ioRdEnd && second_q && !drive_q && sawFirst_q
    && ioDataIn[1:0] == `ICC_SENSE_SECOND;
  assign isoTake = inIso && isoPend_q && ioRdEnd && second_q && !lose && bitIdx_q == 3'h7;

  // Storage pointer control
  assign fif.restart = wakeWr;
  assign fif.take = isoTake || resTake;

  // Card state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cardState <= icc_pkg::ICC_WAIT_KEY;
    end else if (cmdWr && ioDataIn[`ICC_CMD_WAITKEY]) begin
      cardState <= icc_pkg::ICC_WAIT_KEY;
    end else begin
      case (cardState)
        icc_pkg::ICC_WAIT_KEY: begin
          if (keyOk) begin
            cardState <= icc_pkg::ICC_SLEEP;
          end
        end
        icc_pkg::ICC_SLEEP: begin
          if (wakeMatch) begin
            cardState <= (ioDataIn == 8'h00) ? icc_pkg::ICC_ISOLATE : icc_pkg::ICC_CONFIG;
          end
        end
        icc_pkg::ICC_ISOLATE: begin
          if (lose) begin
            cardState <= icc_pkg::ICC_SLEEP;
          end else if (handleWr) begin
            cardState <= icc_pkg::ICC_CONFIG;
          end else if (wakeWr && !wakeMatch) begin
            cardState <= icc_pkg::ICC_SLEEP;
          end
        end
        icc_pkg::ICC_CONFIG: begin
          if (wakeWr && !wakeMatch) begin
            cardState <= icc_pkg::ICC_SLEEP;
          end
        end
        default: begin
          cardState <= icc_pkg::ICC_WAIT_KEY;
        end
      endcase
    end
  end

  // Read answer selection
  logic rdDrive;
  logic [7:0] rdValue;

  always_comb begin
    rdDrive = 1'b0;
    rdValue = 8'h00;
    resTake = 1'b0;
    if (rdPortRd) begin
      case (index_q)
        `ICC_IDX_ISOL: begin
          // Full byte is driven though only D[1:0] are sensed by others
          if (isoRd && (second_q ? drive_q : curBit)) begin
            rdDrive = 1'b1;
            rdValue = second_q ? `ICC_ISO_SECOND : `ICC_ISO_FIRST;
          end
        end
        `ICC_IDX_RES: begin
          if (inCfg) begin
            rdDrive = 1'b1;
            rdValue = fif.data;
            resTake = fif.ready;
          end
        end
        `ICC_IDX_STAT: begin
          if (inCfg) begin
            rdDrive = 1'b1;
            rdValue[`ICC_STAT_READY] = fif.ready;
          end
        end
        `ICC_IDX_HANDLE: begin
          if (inCfg) begin
            rdDrive = 1'b1;
            rdValue = cardHandle;
          end
        end
        `ICC_IDX_LUN: begin
          if (inCfg) begin
            rdDrive = 1'b1;
            rdValue = `ICC_LUN_VALUE;
          end
        end
        default: begin
          // Index 0x00, the write-only command and wake, and unknown indexes stay off the bus
          rdDrive = 1'b0;
        end
      endcase
    end
  end

  // Bus driver held from the cycle after the read strobe to the end strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ioDataOe <= 1'b0;
      ioDataOut <= 8'h00;
    end else if (rdDrive) begin
      ioDataOe <= 1'b1;
      ioDataOut <= rdValue;
    end else if (ioRdEnd) begin
      ioDataOe <= 1'b0;
      ioDataOut <= 8'h00;
    end
  end

endmodule // icc_card_ctrl

// file: hdl/icc_key_detect.sv
// Initiation key checker for the address port.
// Assumes one-cycle write and read strobes already decoded for that port.
`timescale 1ns/10ps
`include "icc_map.svh"
module icc_key_detect #(
  parameter int KEY_LEN = `ICC_KEY_LEN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic portWr,
  input wire logic portRd,
  input wire logic [7:0] wrData,
  output logic keyOk
);

  initial begin
    if (KEY_LEN < 2 || KEY_LEN > 63) begin
      $error("icc_key_detect: KEY_LEN out of range");
    end
  end

  localparam logic [5:0] LAST = 6'(KEY_LEN - 1);

  logic [7:0] expect_q;
  logic [5:0] count_q;

  function automatic logic [7:0] nextKey(input logic [7:0] cur);
    nextKey = {cur[1] ^ cur[0], cur[7:1]};
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      expect_q <= `ICC_KEY_SEED;
      count_q <= 6'h00;
      keyOk <= 1'b0;
    end else begin
      keyOk <= 1'b0;
      if (!enable || portRd) begin
        expect_q <= `ICC_KEY_SEED;
        count_q <= 6'h00;
      end else if (portWr) begin
        if (wrData == expect_q) begin
          if (count_q == LAST) begin
            keyOk <= 1'b1;
            expect_q <= `ICC_KEY_SEED;
            count_q <= 6'h00;
          end else begin
            expect_q <= nextKey(expect_q);
            count_q <= count_q + 6'h01;
          end
        end else if (wrData == `ICC_KEY_SEED) begin
          // A broken sequence may itself be the start of a fresh key
          expect_q <= nextKey(`ICC_KEY_SEED);
          count_q <= 6'h01;
        end else begin
          expect_q <= `ICC_KEY_SEED;
          count_q <= 6'h00;
        end
      end
    end
  end

endmodule // icc_key_detect

// file: hdl/icc_res_fetch.sv
// Sequential byte reader for the serial identifier and resource data.
// Assumes storage holding memReq until one memAck pulse with memData.
`timescale 1ns/10ps
`include "icc_map.svh"
module icc_res_fetch #(
  parameter int ADDR_W = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  icc_fetch_if.fetch fif,
  output logic memReq,
  output logic [ADDR_W-1:0] memAddr,
  input wire logic [7:0] memData,
  input wire logic memAck
);

  initial begin
    if (ADDR_W < 4 || ADDR_W > 16) begin
      $error("icc_res_fetch: ADDR_W out of range");
    end
  end

  logic redo_q;
  logic ready_q;
  logic [7:0] data_q;

  assign fif.ready = ready_q;
  assign fif.data = data_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memReq <= 1'b1;
      memAddr <= '0;
      redo_q <= 1'b0;
      ready_q <= 1'b0;
      data_q <= 8'h00;
    end else if (fif.restart) begin
      memAddr <= '0;
      ready_q <= 1'b0;
      // An answer already on its way belongs to the old pointer
      redo_q <= memReq;
      memReq <= 1'b1;
    end else if (memReq && memAck) begin
      if (redo_q) begin
        redo_q <= 1'b0;
      end else begin
        memReq <= 1'b0;
        ready_q <= 1'b1;
        data_q <= memData;
      end
    end else if (fif.take && ready_q) begin
      ready_q <= 1'b0;
      memAddr <= memAddr + 1'b1;
      memReq <= 1'b1;
    end
  end

endmodule // icc_res_fetch

// file: include/icc_fetch_if.sv
// Link between the card controller and its storage fetch unit.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface icc_fetch_if;
  logic restart;
  logic take;
  logic ready;
  logic [7:0] data;

  modport ctrl (output restart, output take, input ready, input data);
  modport fetch (input restart, input take, output ready, output data);
endinterface

// file: include/icc_map.svh
// Offsets, field positions, reset values and fixed patterns of the card control block.
// Assumes inclusion by bare name from any file of the block.
`ifndef ICC_MAP_SVH
`define ICC_MAP_SVH

`define ICC_ADDR_PORT 12'h279
`define ICC_WDATA_PORT 12'hA79
`define ICC_RDPORT_HI 2'b00
`define ICC_RDPORT_LO 2'b11
`define ICC_RDPORT_RST 8'h00

`define ICC_IDX_RDPORT 8'h00
`define ICC_IDX_ISOL 8'h01
`define ICC_IDX_CMD 8'h02
`define ICC_IDX_WAKE 8'h03
`define ICC_IDX_RES 8'h04
`define ICC_IDX_STAT 8'h05
`define ICC_IDX_HANDLE 8'h06
`define ICC_IDX_LUN 8'h07
`define ICC_IDX_RST 8'h00

`define ICC_CMD_DEVRST 0
`define ICC_CMD_WAITKEY 1
`define ICC_CMD_CLRHANDLE 2
`define ICC_STAT_READY 0

`define ICC_HANDLE_RST 8'h00
`define ICC_LUN_VALUE 8'h00
`define ICC_KEY_SEED 8'h6A
`define ICC_KEY_LEN 32
`define ICC_ID_BITS 7'h48
`define ICC_ISO_FIRST 8'h55
`define ICC_ISO_SECOND 8'hAA
`define ICC_SENSE_FIRST 2'b01
`define ICC_SENSE_SECOND 2'b10

`endif

// file: include/icc_pkg.sv
// Types shared by the card control block.
// Assumes nothing of its surroundings.
package icc_pkg;

  // Gray order along key wait, sleep, isolation, config
  typedef enum logic [1:0] {
    ICC_WAIT_KEY = 2'b00,
    ICC_SLEEP = 2'b01,
    ICC_ISOLATE = 2'b11,
    ICC_CONFIG = 2'b10
  } icc_state_t;

endpackage

// file: tb/icc_card_ctrl_properties.sv
// Port-level checks of the card control block.
// Assumes a bind from the testbench top and index set through the address port.
`timescale 1ns/10ps
`include "icc_map.svh"
module icc_card_ctrl_properties #(
  parameter int ADDR_W = 9
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [11:0] ioAddr,
  input wire logic ioWrStb,
  input wire logic ioRdStb,
  input wire logic ioRdEnd,
  input wire logic [7:0] ioDataIn,
  input wire logic [7:0] ioDataOut,
  input wire logic ioDataOe,
  input wire logic memReq,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic [7:0] memData,
  input wire logic memAck,
  input wire icc_pkg::icc_state_t cardState,
  input wire logic [7:0] cardHandle,
  input wire logic [9:0] readPortAddr,
  input wire logic ldReset
);
  logic [7:0] idx_q;
  logic dataWr;
  logic rdHit;
  logic cfgCmd;
  assign dataWr = ioWrStb && ioAddr == `ICC_WDATA_PORT;
  assign rdHit = ioRdStb && ioAddr == {2'b00, readPortAddr};
  assign cfgCmd = dataWr && idx_q == `ICC_IDX_CMD && cardState == icc_pkg::ICC_CONFIG
    && cardHandle != 8'h00;
  // Key wait leaves the index alone: those writes belong to the key checker
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_q <= `ICC_IDX_RST;
    end else if (ioWrStb && ioAddr == `ICC_ADDR_PORT && cardState != icc_pkg::ICC_WAIT_KEY) begin
      idx_q <= ioDataIn;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_reset_state: assert property (disable iff (1'b0) !arst_n |->
    cardState == icc_pkg::ICC_WAIT_KEY && cardHandle == `ICC_HANDLE_RST) else $error("reset state");
  a_oe_release: assert property (ioRdEnd |=> !ioDataOe) else $error("bus held");
  a_key_nodrive: assert property (rdHit && cardState == icc_pkg::ICC_WAIT_KEY |=> !ioDataOe)
    else $error("drive in key wait");
  // The port address passes two flops: read port register, then the output
  a_rdport_load: assert property (dataWr && idx_q == `ICC_IDX_RDPORT && cardState[1] |=>
    ##1 readPortAddr == {$past(ioDataIn, 2), `ICC_RDPORT_LO}) else $error("read port");
  a_cmd_keywait: assert property (cfgCmd && ioDataIn[`ICC_CMD_WAITKEY]
    && !ioDataIn[`ICC_CMD_CLRHANDLE] |=>
    cardState == icc_pkg::ICC_WAIT_KEY && $stable(cardHandle)) else $error("wait key cmd");
  a_cmd_clear: assert property (cfgCmd && ioDataIn[`ICC_CMD_CLRHANDLE] |=>
    cardHandle == 8'h00) else $error("handle clear");
  a_ldreset_pulse: assert property (cfgCmd && ioDataIn[`ICC_CMD_DEVRST] |=>
    ldReset ##1 !ldReset) else $error("device reset pulse");
  a_wake_isolate: assert property (dataWr && idx_q == `ICC_IDX_WAKE
    && cardState == icc_pkg::ICC_SLEEP && ioDataIn == 8'h00 && cardHandle == 8'h00
    |=> cardState == icc_pkg::ICC_ISOLATE) else $error("wake to isolation");
  a_wake_restart: assert property (dataWr && idx_q == `ICC_IDX_WAKE
    && cardState != icc_pkg::ICC_WAIT_KEY |=> memAddr == {ADDR_W{1'b0}}) else $error("pointer");
  a_handle_read: assert property (rdHit && idx_q == `ICC_IDX_HANDLE
    && cardState == icc_pkg::ICC_CONFIG |=> ioDataOe && ioDataOut == $past(cardHandle))
    else $error("handle read");
  a_unit_zero: assert property (rdHit && idx_q == `ICC_IDX_LUN
    && cardState == icc_pkg::ICC_CONFIG |=> ioDataOe && ioDataOut == `ICC_LUN_VALUE)
    else $error("unit select read");
endmodule // icc_card_ctrl_properties

// file: tb/icc_storage_model.sv
// Serial storage behind the fetch port: one memAck per request after LAT cycles.
// Assumes memReq held until acknowledged; byte value is its address xor 0xA5.
`timescale 1ns/10ps
module icc_storage_model #(
  parameter int ADDR_W = 9,
  parameter int LAT = 3
) (
  input wire logic clk,
  input wire logic memReq,
  input wire logic [ADDR_W-1:0] memAddr,
  output logic [7:0] memData,
  output logic memAck
);
  int cnt = 0;
  initial memData = 8'h00;
  initial memAck = 1'b0;
  // Data is scrambled outside the ack cycle so a stale capture shows up
  always @(posedge clk) begin
    memAck <= 1'b0;
    memData <= ~memData;
    if (memReq && !memAck) begin
      cnt <= cnt + 1;
      if (cnt >= LAT) begin
        cnt <= 0;
        memAck <= 1'b1;
        memData <= memAddr[7:0] ^ 8'hA5;
      end
    end
  end
endmodule // icc_storage_model

// file: tb/tb.sv
// Testbench of the card control block: host accesses over the three ports.
// Assumes the storage model and the property checker beside the design.
`timescale 1ns/10ps
`include "icc_map.svh"
module tb;
  logic clk, arst_n, ioWrStb, ioRdStb, ioRdEnd, ioDataOe, memReq, memAck, ldReset, lastOe;
  logic [11:0] ioAddr, rport;
  logic [7:0] ioDataIn, ioDataOut, memData, cardHandle, v0, v1, idByte;
  logic [8:0] memAddr;
  logic [9:0] readPortAddr;
  icc_pkg::icc_state_t cardState;
  int num_errors, comparisons;

  icc_card_ctrl #(.ADDR_W(9)) dut (.clk(clk), .arst_n(arst_n), .ioAddr(ioAddr),
    .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioRdEnd(ioRdEnd), .ioDataIn(ioDataIn),
    .ioDataOut(ioDataOut), .ioDataOe(ioDataOe), .memReq(memReq), .memAddr(memAddr),
    .memData(memData), .memAck(memAck), .cardState(cardState), .cardHandle(cardHandle),
    .readPortAddr(readPortAddr), .ldReset(ldReset));
  icc_storage_model #(.ADDR_W(9), .LAT(3)) mem (.clk(clk), .memReq(memReq),
    .memAddr(memAddr), .memData(memData), .memAck(memAck));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    ioAddr = a;
    ioDataIn = d;
    ioWrStb = 1'b1;
    @(negedge clk);
    ioWrStb = 1'b0;
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    wr(`ICC_ADDR_PORT, idx);
    wr(`ICC_WDATA_PORT, d);
    @(negedge clk);
  endtask

  // Other is what the rest of the bus shows when the card floats
  task automatic rd(input logic [11:0] a, input logic [7:0] other, output logic [7:0] v);
    @(negedge clk);
    ioAddr = a;
    ioRdStb = 1'b1;
    @(negedge clk);
    ioRdStb = 1'b0;
    lastOe = ioDataOe;
    ioDataIn = ioDataOe ? ioDataOut : other;
    v = ioDataIn;
    ioRdEnd = 1'b1;
    @(negedge clk);
    ioRdEnd = 1'b0;
    ioDataIn = ~ioDataIn;
  endtask

  task automatic rd_idx(input logic [7:0] idx, input logic [7:0] other, output logic [7:0] v);
    wr(`ICC_ADDR_PORT, idx);
    rd(rport, other, v);
  endtask

  task automatic send_key(input int breakAt);
    logic [7:0] k;
    logic [7:0] junk;
    k = `ICC_KEY_SEED;
    for (int i = 0; i < `ICC_KEY_LEN; i++) begin
      if (i == breakAt) begin
        rd(`ICC_ADDR_PORT, 8'hFF, junk);
      end
      wr(`ICC_ADDR_PORT, k);
      k = {k[0] ^ k[1], k[7:1]};
    end
    repeat (3) @(negedge clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    {arst_n, ioWrStb, ioRdStb, ioRdEnd, ioAddr, ioDataIn} = '0;
    rport = 12'h003;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(cardState, icc_pkg::ICC_WAIT_KEY, "state");
    chk(readPortAddr, 10'h003, "read port");
    send_key(16);
    chk(cardState, icc_pkg::ICC_WAIT_KEY, "broken key");
    send_key(99);
    chk(cardState, icc_pkg::ICC_SLEEP, "key");
    reg_wr(`ICC_IDX_WAKE, 8'h00);
    chk(cardState, icc_pkg::ICC_ISOLATE, "wake zero");
    chk(memAddr, 9'h000, "pointer");
    chk(memReq, 1'b1, "fetch restart");
    reg_wr(`ICC_IDX_RDPORT, 8'h80);
    chk(readPortAddr, 10'h203, "read port");
    rport = 12'h203;
    wr(`ICC_ADDR_PORT, `ICC_IDX_ISOL);
    repeat (10) @(negedge clk);
    rd(rport, 8'hFF, v0);
    rd(rport, 8'hFF, v1);
    chk({v0, v1}, {`ICC_ISO_FIRST, `ICC_ISO_SECOND}, "one bit pair");
    rd(rport, `ICC_ISO_FIRST, v0);
    chk(lastOe, 1'b0, "zero bit float");
    rd(rport, `ICC_ISO_SECOND, v1);
    chk(cardState, icc_pkg::ICC_SLEEP, "lost pair");
    reg_wr(`ICC_IDX_WAKE, 8'h00);
    // Lone card: a floating bus reads as the pull-up level
    wr(`ICC_ADDR_PORT, `ICC_IDX_ISOL);
    for (int k = 0; k < 9; k++) begin
      for (int j = 0; j < 8; j++) begin
        repeat (10) @(negedge clk);
        rd(rport, 8'hFF, v0);
        rd(rport, 8'hFF, v1);
        idByte[j] = (v0 == `ICC_ISO_FIRST) && (v1 == `ICC_ISO_SECOND);
      end
      chk(idByte, 8'(k) ^ 8'hA5, "serial id");
    end
    rd(rport, 8'hFF, v0);
    chk(lastOe, 1'b0, "isolation over");
    reg_wr(`ICC_IDX_HANDLE, 8'h05);
    chk({cardState, cardHandle}, {icc_pkg::ICC_CONFIG, 8'h05}, "handle set");
    rd_idx(`ICC_IDX_HANDLE, 8'hFF, v0);
    chk(v0, 8'h05, "handle read");
    rd_idx(`ICC_IDX_LUN, 8'hFF, v0);
    chk(v0, `ICC_LUN_VALUE, "unit select");
    rd_idx(`ICC_IDX_CMD, 8'h5A, v0);
    chk(lastOe, 1'b0, "command read");
    reg_wr(`ICC_IDX_WAKE, 8'h05);
    for (int i = 0; i < 2; i++) begin
      v0 = 8'h00;
      for (int p = 0; p < 20 && !v0[`ICC_STAT_READY]; p++) rd_idx(`ICC_IDX_STAT, 8'h00, v0);
      chk(v0[`ICC_STAT_READY], 1'b1, "ready");
      rd_idx(`ICC_IDX_RES, 8'h00, v1);
      chk(v1, 8'hA5 ^ i[7:0], "resource byte");
    end
    reg_wr(`ICC_IDX_CMD, 8'h01);
    chk({cardState, cardHandle}, {icc_pkg::ICC_CONFIG, 8'h05}, "device reset");
    reg_wr(`ICC_IDX_CMD, 8'h02);
    chk({cardState, cardHandle}, {icc_pkg::ICC_WAIT_KEY, 8'h05}, "wait key");
    send_key(99);
    reg_wr(`ICC_IDX_WAKE, 8'h05);
    chk(cardState, icc_pkg::ICC_CONFIG, "wake handle");
    reg_wr(`ICC_IDX_CMD, 8'h04);
    chk(cardHandle, 8'h00, "handle clear");
    reg_wr(`ICC_IDX_HANDLE, 8'h07);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(ldReset, 1'b1, "device reset held");
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk({cardState, cardHandle}, {icc_pkg::ICC_WAIT_KEY, 8'h00}, "bus reset");
    give_verdict();
  end
endmodule // tb

bind icc_card_ctrl icc_card_ctrl_properties #(.ADDR_W(ADDR_W)) u_props (.clk(clk),
  .arst_n(arst_n), .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
  .ioRdEnd(ioRdEnd), .ioDataIn(ioDataIn), .ioDataOut(ioDataOut), .ioDataOe(ioDataOe),
  .memReq(memReq), .memAddr(memAddr), .memData(memData), .memAck(memAck),
  .cardState(cardState), .cardHandle(cardHandle), .readPortAddr(readPortAddr),
  .ldReset(ldReset));
